// ===== core/sic_pkg.sv
// constants for the snapshot input conditioner
package sic_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned SAMPLE_US = 160;
    localparam int unsigned SAMPLE_CYC = (CLK_HZ / 1000000) * SAMPLE_US;
    localparam int unsigned MS_CYC = CLK_HZ / 1000;
    localparam logic [7:0] FILT_DEFAULT = 8'h0a;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_FILT = 12'h004;
    localparam logic [11:0] A_STAT = 12'h008;
    localparam logic [11:0] A_MASK = 12'h00c;
    localparam logic [11:0] A_CLR = 12'h010;
    localparam int B_EN = 0;
    localparam int B_PRE = 1;
    localparam int B_POL = 2;
    localparam int B_KEYIN = 3;
    localparam int B_KEYOUT = 4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// ===== core/sic_top.sv
// snapshot trigger input conditioner with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module sic_top #(
    parameter int unsigned SAMPLE_CYC = sic_pkg::SAMPLE_CYC,
    parameter int unsigned MS_CYC = sic_pkg::MS_CYC
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic SNAP_PIN,
    input wire logic KEY_PIN,
    output logic PIN_EVENT,
    output logic KEY_EVENT,
    output logic KEY_LATCHED,
    output logic WAIT_CANCEL,
    output logic IRQ,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    logic [1:0] s1_q, s2_q;
    logic [15:0] tick_q, tick_d;
    logic tick;
    logic [1:0] smp_q, smp_d, prev_q, prev_d;
    logic [1:0] qual;
    logic [7:0] lk_ms_q [2];
    logic [7:0] lk_ms_d [2];
    logic [15:0] lk_sub_q [2];
    logic [15:0] lk_sub_d [2];
    logic [1:0] ev_d;
    logic en_q, en_d, pre_q, pre_d, pol_q, pol_d, rst_done_q;
    logic [7:0] filt_q, filt_d;
    logic klat_q, klat_d, cancel_d;
    logic [1:0] st_q, st_d, msk_q, msk_d;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [11:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic wr_go, ctrl_wr;
    logic wstrb_q, wstrb_d;
    logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

    // two-stage synchronisers for both pins
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
        end else begin
            s1_q <= {KEY_PIN, SNAP_PIN};
            s2_q <= s1_q;
        end
    end

    assign tick = (tick_q == 16'(SAMPLE_CYC - 1));

    always_comb begin
        tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
        smp_d = smp_q;
        prev_d = prev_q;
        if (tick) begin
            smp_d = s2_q;
            prev_d = smp_q;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            tick_q <= 16'h0000;
            smp_q <= 2'h3;
            prev_q <= 2'h3;
        end else begin
            tick_q <= tick_d;
            smp_q <= smp_d;
            prev_q <= prev_d;
        end
    end

    // per source edge detect with a lockout timer for each source
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_src
            always_comb begin
                qual[g] = pol_q ? (smp_q[g] & ~prev_q[g]) : (~smp_q[g] & prev_q[g]);
                lk_ms_d[g] = lk_ms_q[g];
                lk_sub_d[g] = lk_sub_q[g];
                ev_d[g] = 1'b0;
                if (lk_ms_q[g] != 8'h00) begin
                    if (lk_sub_q[g] == 16'(MS_CYC - 1)) begin
                        lk_sub_d[g] = 16'h0000;
                        lk_ms_d[g] = lk_ms_q[g] - 8'h01;
                    end else begin
                        lk_sub_d[g] = lk_sub_q[g] + 16'h0001;
                    end
                end else if (tick && (smp_q[g] != prev_q[g])) begin
                    // a change seen once the lockout has expired starts a new one, a qualifying one fires at once if enabled
                    ev_d[g] = qual[g] & en_q;
                    lk_ms_d[g] = filt_q;
                    lk_sub_d[g] = 16'h0000;
                end
            end
            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    lk_ms_q[g] <= 8'h00;
                    lk_sub_q[g] <= 16'h0000;
                end else begin
                    lk_ms_q[g] <= lk_ms_d[g];
                    lk_sub_q[g] <= lk_sub_d[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PIN_EVENT <= 1'b0;
            KEY_EVENT <= 1'b0;
        end else begin
            PIN_EVENT <= ev_d[0];
            KEY_EVENT <= ev_d[1];
        end
    end

    // axi4-lite slave; byte lane 0 must be strobed for a register to change
    assign wr_go = aw_q && w_q && !bv_q;
    assign ctrl_wr = wr_go && (awa_q == sic_pkg::A_CTRL) && wstrb_q;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        wstrb_d = wstrb_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        en_d = en_q;
        pre_d = pre_q;
        pol_d = pol_q;
        filt_d = filt_q;
        msk_d = msk_q;
        st_d = st_q;
        klat_d = klat_q;
        cancel_d = 1'b0;
        if (AWVALID && !aw_q) begin
            aw_d = 1'b1;
            awa_d = AWADDR;
        end
        if (WVALID && !w_q) begin
            w_d = 1'b1;
            wd_d = WDATA;
            wstrb_d = WSTRB[0];
        end
        if (!rst_done_q) begin
            en_d = pre_q;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = sic_pkg::RESP_OK;
            case (awa_q)
                sic_pkg::A_CTRL: begin
                    if (wstrb_q) begin
                        en_d = wd_q[sic_pkg::B_EN];
                        pre_d = wd_q[sic_pkg::B_PRE];
                        pol_d = wd_q[sic_pkg::B_POL];
                        klat_d = 1'b0;
                        cancel_d = 1'b1;
                    end
                end
                sic_pkg::A_FILT: begin
                    if (wstrb_q) begin
                        filt_d = wd_q[7:0];
                    end
                end
                sic_pkg::A_STAT: begin
                    if (wstrb_q) begin
                        st_d = st_q & ~wd_q[1:0];
                    end
                end
                sic_pkg::A_MASK: begin
                    if (wstrb_q) begin
                        msk_d = wd_q[1:0];
                    end
                end
                default: br_d = sic_pkg::RESP_ERR;
            endcase
        end
        // a key event latches after any clear in the same cycle
        if (ev_d[1]) begin
            klat_d = 1'b1;
        end
        st_d = st_d | ev_d;
        if (bv_q && BREADY) begin
            bv_d = 1'b0;
        end
        if (rv_q && RREADY) begin
            rv_d = 1'b0;
        end else if (ARVALID && !rv_q) begin
            rv_d = 1'b1;
            rr_d = sic_pkg::RESP_OK;
            rd_d = 32'h0000_0000;
            case (ARADDR)
                sic_pkg::A_CTRL: begin
                    rd_d[sic_pkg::B_EN] = en_q;
                    rd_d[sic_pkg::B_PRE] = pre_q;
                    rd_d[sic_pkg::B_POL] = pol_q;
                    rd_d[sic_pkg::B_KEYOUT] = klat_q;
                end
                sic_pkg::A_FILT: rd_d[7:0] = filt_q;
                sic_pkg::A_STAT: rd_d[1:0] = st_q;
                sic_pkg::A_MASK: rd_d[1:0] = msk_q;
                default: rr_d = sic_pkg::RESP_ERR;
            endcase
        end
        // ready flops mirror the hold flags so the bus sees register outputs
        awrdy_d = !aw_d;
        wrdy_d = !w_d;
        arrdy_d = !rv_d;
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            aw_q <= 1'b0;
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
            arrdy_q <= 1'b1;
            w_q <= 1'b0;
            awa_q <= 12'h000;
            wd_q <= 32'h0000_0000;
            wstrb_q <= 1'b0;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rr_q <= 2'h0;
            en_q <= 1'b0;
            pre_q <= 1'b0;
            pol_q <= 1'b0;
            filt_q <= sic_pkg::FILT_DEFAULT;
            msk_q <= 2'h0;
            st_q <= 2'h0;
            klat_q <= 1'b0;
            rst_done_q <= 1'b0;
            WAIT_CANCEL <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            aw_q <= aw_d;
            awrdy_q <= awrdy_d;
            wrdy_q <= wrdy_d;
            arrdy_q <= arrdy_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            wstrb_q <= wstrb_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            en_q <= en_d;
            pre_q <= pre_d;
            pol_q <= pol_d;
            filt_q <= filt_d;
            msk_q <= msk_d;
            st_q <= st_d;
            klat_q <= klat_d;
            rst_done_q <= 1'b1;
            WAIT_CANCEL <= cancel_d;
            IRQ <= |(st_d & msk_d);
        end
    end

    assign AWREADY = awrdy_q;
    assign WREADY = wrdy_q;
    assign BVALID = bv_q;
    assign BRESP = br_q;
    assign ARREADY = arrdy_q;
    assign RVALID = rv_q;
    assign RDATA = rd_q;
    assign RRESP = rr_q;
    assign KEY_LATCHED = klat_q;

    a_event_gated: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !en_q |=> !PIN_EVENT && !KEY_EVENT) else $error("event while disabled");
    a_write_cancels: assert property (@(posedge CLOCK) disable iff (!RESETN)
        ctrl_wr |=> WAIT_CANCEL) else $error("no cancel on enable write");
    a_write_clears_key: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (ctrl_wr && !ev_d[1]) |=> !klat_q) else $error("key latch kept");
    a_key_latches: assert property (@(posedge CLOCK) disable iff (!RESETN)
        KEY_EVENT |-> klat_q) else $error("key event not latched");
    a_cancel_single: assert property (@(posedge CLOCK) disable iff (!RESETN)
        WAIT_CANCEL |=> !WAIT_CANCEL) else $error("cancel longer than one cycle");
    a_preset_loaded: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !rst_done_q |=> en_q == $past(pre_q)) else $error("enable not preset");
    a_pulse_single: assert property (@(posedge CLOCK) disable iff (!RESETN)
        PIN_EVENT |=> !PIN_EVENT) else $error("event longer than one cycle");
    a_key_pulse_single: assert property (@(posedge CLOCK) disable iff (!RESETN)
        KEY_EVENT |=> !KEY_EVENT) else $error("key event longer than one cycle");
    a_lockout_holds: assert property (@(posedge CLOCK) disable iff (!RESETN)
        PIN_EVENT && filt_q != 8'h00 |-> lk_ms_q[0] == filt_q) else $error("lockout not loaded");
    a_lockout_blocks: assert property (@(posedge CLOCK) disable iff (!RESETN)
        lk_ms_q[0] != 8'h00 |=> !PIN_EVENT) else $error("event during lockout");
    a_key_lockout_blocks: assert property (@(posedge CLOCK) disable iff (!RESETN)
        lk_ms_q[1] != 8'h00 |=> !KEY_EVENT) else $error("key event during lockout");
    a_zero_filter: assert property (@(posedge CLOCK) disable iff (!RESETN)
        PIN_EVENT && filt_q == 8'h00 |-> lk_ms_q[0] == 8'h00) else $error("lockout with zero filter");
    a_edge_polarity: assert property (@(posedge CLOCK) disable iff (!RESETN)
        PIN_EVENT |-> $past(pol_q ? smp_q[0] : !smp_q[0])) else $error("wrong edge");
    a_sample_spacing: assert property (@(posedge CLOCK) disable iff (!RESETN)
        tick |=> !tick) else $error("sample tick too close");
    a_sample_taken: assert property (@(posedge CLOCK) disable iff (!RESETN)
        tick |=> smp_q == $past(s2_q)) else $error("sample not taken on tick");
endmodule
`default_nettype wire

// ===== sim/sic_trig_src.sv
// trigger source model: clean levels held for a minimum time
`timescale 1ns/1ps
`default_nettype none
module sic_trig_src #(
    parameter int MIN_HOLD = 10
) (
    input wire logic clk,
    output logic pin
);
    initial pin = 1'b1;
    // clean edges, each level held at least the minimum
    task automatic drive(input logic v, input int hold);
        int k;
        pin <= v;
        for (k = 0; k < ((hold < MIN_HOLD) ? MIN_HOLD : hold); k++) begin
            @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the snapshot input conditioner
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic snap_pin, key_pin, pin_event, key_event, key_latched, wait_cancel, irq;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] seed = 16'h004d;
    int miscompares = 0, n_checks = 0, n_pin = 0, n_key = 0, n_wc = 0, base;
    always #20 clock = ~clock;
    sic_top #(.SAMPLE_CYC(8), .MS_CYC(4)) i_dut (.CLOCK(clock), .RESETN(resetn),
        .SNAP_PIN(snap_pin), .KEY_PIN(key_pin), .PIN_EVENT(pin_event), .KEY_EVENT(key_event),
        .KEY_LATCHED(key_latched), .WAIT_CANCEL(wait_cancel), .IRQ(irq),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready));
    sic_trig_src i_pin (.clk(clock), .pin(snap_pin));
    sic_trig_src i_key (.clk(clock), .pin(key_pin));
    // count cycles with a pulse high at mid-cycle, so a stretched pulse counts twice
    always @(negedge clock) begin
        if (pin_event === 1'b1) n_pin++;
        if (key_event === 1'b1) n_key++;
        if (wait_cancel === 1'b1) n_wc++;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] ctrl(input logic en, input logic pol, input logic lat);
        ctrl = 32'h0;
        ctrl[sic_pkg::B_EN] = en;
        ctrl[sic_pkg::B_POL] = pol;
        ctrl[sic_pkg::B_KEYOUT] = lat;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one bus transfer; ready sampled mid-cycle, released after the taking edge
    task automatic ax(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, done;
        int n;
        @(posedge clock);
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hf;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (n = 0; n < 100; n++) begin
            @(negedge clock);
            ta = wr ? (awvalid & awready) : (arvalid & arready);
            tw = wvalid & wready;
            done = wr ? bvalid : rvalid;
            resp = wr ? bresp : rresp;
            rd = rdata;
            @(posedge clock);
            if (ta && wr) awvalid <= 1'b0;
            if (ta && !wr) arvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) begin
                bready <= 1'b0;
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        give_verdict();
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        ax(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic irqchk(input logic exp);
        @(negedge clock);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    // one hold covers sync, two sample intervals and the event pulse
    task automatic src(input int s, input logic v);
        if (s == 0) i_pin.drive(v, 24);
        else i_key.drive(v, 24);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rdchk(sic_pkg::A_CTRL, 32'h0);
        rdchk(sic_pkg::A_FILT, {24'h0, sic_pkg::FILT_DEFAULT});
        ax(1'b0, 12'h100, 32'h0);
        chk({30'h0, resp}, {30'h0, sic_pkg::RESP_ERR});
        ax(1'b1, 12'h100, 32'h1);
        chk({30'h0, resp}, {30'h0, sic_pkg::RESP_ERR});
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            ax(1'b1, sic_pkg::A_FILT, {24'h0, seed[7:0]});
            rdchk(sic_pkg::A_FILT, {24'h0, seed[7:0]});
        end
        $display("test reset and readback done");
        ax(1'b1, sic_pkg::A_FILT, 32'h0);
        for (int p = 0; p < 2; p++) begin
            base = n_wc;
            ax(1'b1, sic_pkg::A_CTRL, ctrl(1'b1, p[0], 1'b0));
            chk(n_wc - base, 1);
            rdchk(sic_pkg::A_CTRL, ctrl(1'b1, p[0], 1'b0));
            src(0, ~p[0]);
            base = n_pin;
            src(0, p[0]);
            chk(n_pin - base, 1);
            src(0, ~p[0]);
            chk(n_pin - base, 1);
        end
        $display("test polarity done");
        ax(1'b1, sic_pkg::A_CTRL, ctrl(1'b0, 1'b0, 1'b0));
        base = n_pin + n_key;
        for (int k = 0; k < 3; k++) src(0, ~k[0]);
        src(1, 1'b0);
        src(1, 1'b1);
        chk(n_pin + n_key - base, 0);
        $display("test disable done");
        ax(1'b1, sic_pkg::A_FILT, 32'hff);
        rdchk(sic_pkg::A_FILT, 32'hff);
        ax(1'b1, sic_pkg::A_CTRL, ctrl(1'b1, 1'b0, 1'b0));
        for (int s = 0; s < 2; s++) begin
            base = n_pin + n_key;
            for (int k = 0; k < 4; k++) src(s, k[0]);
            chk(n_pin + n_key - base, 1);
            repeat (1100) @(posedge clock);
            src(s, 1'b0);
            chk(n_pin + n_key - base, 2);
            src(s, 1'b1);
        end
        chk(n_key, 2);
        rdchk(sic_pkg::A_CTRL, ctrl(1'b1, 1'b0, 1'b1));
        chk({31'h0, key_latched}, 32'h1);
        ax(1'b1, sic_pkg::A_CTRL, ctrl(1'b1, 1'b0, 1'b0));
        rdchk(sic_pkg::A_CTRL, ctrl(1'b1, 1'b0, 1'b0));
        chk({31'h0, key_latched}, 32'h0);
        $display("test debounce done");
        rdchk(sic_pkg::A_STAT, 32'h3);
        ax(1'b1, sic_pkg::A_MASK, 32'h0);
        irqchk(1'b0);
        ax(1'b1, sic_pkg::A_MASK, 32'h2);
        irqchk(1'b1);
        ax(1'b1, sic_pkg::A_STAT, 32'h3);
        irqchk(1'b0);
        rdchk(sic_pkg::A_STAT, 32'h0);
        $display("test interrupt done");
        ax(1'b1, sic_pkg::A_CTRL, ctrl(1'b1, 1'b1, 1'b0) | (32'h1 << sic_pkg::B_PRE));
        rdchk(sic_pkg::A_CTRL, ctrl(1'b1, 1'b1, 1'b0) | (32'h1 << sic_pkg::B_PRE));
        resetn <= 1'b0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rdchk(sic_pkg::A_CTRL, 32'h0);
        rdchk(sic_pkg::A_FILT, {24'h0, sic_pkg::FILT_DEFAULT});
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
